// *** inc/anr_cfg.svh ***
// Purpose: offsets, field positions, reset values for the ability registers
// Assumes: register index equals byte offset on the plain port
// Notes:   definitions only
`ifndef ANR_CFG_SVH
`define ANR_CFG_SVH

`define ANR_ADDR_W         5
`define ANR_ADV_OFF        5'h04
`define ANR_LP_OFF         5'h05
`define ANR_LPCTL_OFF      5'h10
`define ANR_NP_BIT         15
`define ANR_ACK_BIT        14
`define ANR_RF_BIT         13
`define ANR_RSV14_BIT      14
`define ANR_ASYM_BIT       11
`define ANR_PAUSE_BIT      10
`define ANR_T4_BIT         9
`define ANR_TXFD_BIT       8
`define ANR_TXHD_BIT       7
`define ANR_TFD_BIT        6
`define ANR_THD_BIT        5
`define ANR_SEL_HI         4
`define ANR_SEL_802_3      5'h01
`define ANR_SEL_802_9      5'h02
`define ANR_SEL_RSV_LO     5'h00
`define ANR_SEL_RSV_HI     5'h1f
`define ANR_LP_RESET       16'h0000
`define ANR_ADV_WMASK      16'hbfff

`endif

// *** inc/anr_pkg.sv ***
// Purpose: types shared by the ability register bank
// Assumes: nothing
// Notes:   constants live in anr_cfg.svh
package anr_pkg;
    typedef enum logic [1:0] {
        ANR_ST_RESET,
        ANR_ST_STRAP,
        ANR_ST_RUN
    } anr_state_t;
endpackage

// *** logic/anr_regs.sv ***
// Purpose: local advertisement and partner base page registers of one port
// Assumes: single clock, straps stable around reset release
// Notes:   straps caught on the second enabled clock edge after reset release
//
// Local design decision: strobed register access.
`include "anr_cfg.svh"

module anr_regs (
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   clk_en_i,
    input  wire logic [`ANR_ADDR_W-1:0] addr_i,
    input  wire logic [15:0]            wdata_i,
    input  wire logic                   wr_i,
    input  wire logic                   rd_i,
    output logic      [15:0]            rdata_o,
    input  wire logic                   pause_strap_i,
    input  wire logic [3:0]             indicator_config_straps_i,
    input  wire logic [15:0]            lp_word_i,
    input  wire logic                   lp_word_valid_i,
    output logic      [15:0]            adv_word_o,
    output logic                        reserved_sel_o
);

    anr_pkg::anr_state_t state_reg;
    logic [15:0]         adv_reg;
    logic [15:0]         lp_reg;
    logic [15:0]         adv_next;
    logic [15:0]         lp_next;
    logic [15:0]         rdata_next;
    logic [15:0]         strap_adv;

    // selector codes other than the two defined ones are flagged
    function automatic logic sel_bad(input logic [4:0] sel);
        return (sel != `ANR_SEL_802_3) && (sel != `ANR_SEL_802_9);
    endfunction

    wire logic hit_adv   = (addr_i == `ANR_ADV_OFF);
    wire logic hit_lp    = (addr_i == `ANR_LP_OFF);
    wire logic adv_write = clk_en_i && wr_i && hit_adv;
    wire logic strapping = (state_reg == anr_pkg::ANR_ST_STRAP);

    // strap image: pause and the four technology defaults, selector 802.3
    assign strap_adv = {5'h00, pause_strap_i, 1'b0, indicator_config_straps_i,
                        `ANR_SEL_802_3};

    // bit 14 reserved stays zero; everything else software-owned
    assign adv_next = strapping ? strap_adv
                    : adv_write ? (wdata_i & `ANR_ADV_WMASK)
                    : adv_reg;

    // writes to the partner offset fall through: image is receive-only
    assign lp_next = lp_word_valid_i ? lp_word_i : lp_reg;

    assign rdata_next = hit_adv ? adv_reg
                      : hit_lp  ? lp_reg
                      : 16'h0000;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= anr_pkg::ANR_ST_RESET;
        end else if (clk_en_i) begin
            unique case (state_reg)
                anr_pkg::ANR_ST_RESET: state_reg <= anr_pkg::ANR_ST_STRAP;
                anr_pkg::ANR_ST_STRAP: state_reg <= anr_pkg::ANR_ST_RUN;
                anr_pkg::ANR_ST_RUN:   state_reg <= anr_pkg::ANR_ST_RUN;
            endcase
        end
    end

    // constant reset; strap levels are loaded in the strap step instead
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            adv_reg <= {11'h000, `ANR_SEL_802_3};
        end else if (clk_en_i) begin
            adv_reg <= adv_next;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lp_reg <= `ANR_LP_RESET;
        end else if (clk_en_i) begin
            lp_reg <= lp_next;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o        <= 16'h0000;
            adv_word_o     <= 16'h0000;
            reserved_sel_o <= 1'b0;
        end else if (clk_en_i) begin
            rdata_o        <= rd_i ? rdata_next : 16'h0000;
            adv_word_o     <= adv_reg;
            reserved_sel_o <= sel_bad(adv_reg[`ANR_SEL_HI:0]);
        end
    end

    chk_strap_pause: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && strapping) |=> adv_reg[`ANR_PAUSE_BIT] == $past(pause_strap_i))
        else $error("pause default not taken from strap");

    chk_strap_tech: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && strapping)
        |=> adv_reg[`ANR_TXFD_BIT:`ANR_THD_BIT] == $past(indicator_config_straps_i))
        else $error("technology defaults not taken from straps");

    chk_strap_zero: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && strapping) |=> !adv_reg[`ANR_NP_BIT] && !adv_reg[`ANR_ASYM_BIT]
            && !adv_reg[`ANR_T4_BIT] && adv_reg[`ANR_SEL_HI:0] == `ANR_SEL_802_3)
        else $error("fixed advertisement defaults wrong");

    chk_adv_write: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (adv_write && !strapping) |=> adv_reg == ($past(wdata_i) & `ANR_ADV_WMASK))
        else $error("advertisement write not stored");

    chk_rsv_zero: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        adv_reg[`ANR_RSV14_BIT] == 1'b0)
        else $error("reserved advertisement bit set");

    chk_lp_load: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && lp_word_valid_i) |=> lp_reg == $past(lp_word_i))
        else $error("partner word not loaded");

    chk_lp_nowrite: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (!lp_word_valid_i) |=> $stable(lp_reg))
        else $error("partner image changed without a received word");

    sequence s_read_lp;
        clk_en_i && rd_i && hit_lp;
    endsequence

    chk_read_lp: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_read_lp |=> rdata_o == $past(lp_reg))
        else $error("partner read data wrong");

    chk_read_idle: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && !rd_i) |=> rdata_o == 16'h0000)
        else $error("read data not zero outside a read");

    // a low enable must hold every stored bit, strap steps included
    chk_freeze_adv: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !clk_en_i |=> $stable(adv_reg))
        else $error("advertisement moved while frozen");

    chk_freeze_lp: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !clk_en_i |=> $stable(lp_reg))
        else $error("partner image moved while frozen");

    chk_freeze_rdata: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !clk_en_i |=> $stable(rdata_o))
        else $error("read data moved while frozen");

    chk_freeze_state: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !clk_en_i |=> $stable(state_reg))
        else $error("strap sequencing moved while frozen");

    sequence s_read_adv;
        clk_en_i && rd_i && hit_adv;
    endsequence

    chk_read_adv: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_read_adv |=> rdata_o == $past(adv_reg))
        else $error("advertisement read data wrong");

    chk_read_unmapped: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && rd_i && !hit_adv && !hit_lp) |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");

    // write then read back: the read must see the masked write
    sequence s_write_adv;
        adv_write && !strapping;
    endsequence

    sequence s_write_then_read;
        s_write_adv ##1 (clk_en_i && rd_i && hit_adv && !wr_i);
    endsequence

    chk_write_read: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_then_read |=> rdata_o == ($past(wdata_i, 2) & `ANR_ADV_WMASK))
        else $error("advertisement write not read back");

    chk_adv_hold: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && !adv_write && !strapping) |=> $stable(adv_reg))
        else $error("advertisement changed without a write");

    chk_adv_copy: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        clk_en_i |=> adv_word_o == $past(adv_reg))
        else $error("advertised word not a copy of the register");

    chk_write_np: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_adv |=> adv_reg[`ANR_NP_BIT] == $past(wdata_i[`ANR_NP_BIT]))
        else $error("next page bit not written");

    chk_write_pause: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_adv |=> adv_reg[`ANR_PAUSE_BIT] == $past(wdata_i[`ANR_PAUSE_BIT]))
        else $error("pause bit not written");

    chk_write_asym: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_adv |=> adv_reg[`ANR_ASYM_BIT] == $past(wdata_i[`ANR_ASYM_BIT]))
        else $error("asymmetric pause bit not written");

    chk_write_t4: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_adv |=> adv_reg[`ANR_T4_BIT] == $past(wdata_i[`ANR_T4_BIT]))
        else $error("T4 bit not written");

    chk_write_tx: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_adv
        |=> adv_reg[`ANR_TXFD_BIT:`ANR_TXHD_BIT] == $past(wdata_i[8:7]))
        else $error("100BASE-TX bits not written");

    chk_write_ten: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_adv
        |=> adv_reg[`ANR_TFD_BIT:`ANR_THD_BIT] == $past(wdata_i[6:5]))
        else $error("10BASE-T bits not written");

    chk_write_sel: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_write_adv |=> adv_reg[`ANR_SEL_HI:0] == $past(wdata_i[4:0]))
        else $error("selector not written");

    // the flag trails the register by one edge, so it is checked a cycle on
    chk_sel_good: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && adv_reg[`ANR_SEL_HI:0] == `ANR_SEL_802_3) |=> !reserved_sel_o)
        else $error("802.3 selector flagged as reserved");

    chk_sel_low: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && adv_reg[`ANR_SEL_HI:0] == `ANR_SEL_RSV_LO) |=> reserved_sel_o)
        else $error("reserved selector 00000 not flagged");

    chk_sel_high: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && adv_reg[`ANR_SEL_HI:0] == `ANR_SEL_RSV_HI) |=> reserved_sel_o)
        else $error("reserved selector 11111 not flagged");

    chk_reset_step: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && state_reg == anr_pkg::ANR_ST_RESET) |=> strapping)
        else $error("strap step skipped");

    chk_strap_once: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && strapping) |=> state_reg == anr_pkg::ANR_ST_RUN)
        else $error("strap step repeated");

    chk_run_stays: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && state_reg == anr_pkg::ANR_ST_RUN) |=> state_reg == anr_pkg::ANR_ST_RUN)
        else $error("left run state without reset");

    // software writes at the partner offset must not reach the image
    chk_lp_soft_write: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && wr_i && hit_lp && !lp_word_valid_i) |=> $stable(lp_reg))
        else $error("partner image written by software");

    chk_lp_np: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && lp_word_valid_i) |=> lp_reg[`ANR_NP_BIT] == $past(lp_word_i[15]))
        else $error("partner next page bit not loaded");

    chk_lp_ack: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && lp_word_valid_i) |=> lp_reg[`ANR_ACK_BIT] == $past(lp_word_i[14]))
        else $error("partner acknowledge bit not loaded");

    chk_lp_pause: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && lp_word_valid_i)
        |=> lp_reg[`ANR_ASYM_BIT:`ANR_PAUSE_BIT] == $past(lp_word_i[11:10]))
        else $error("partner pause bits not loaded");

    chk_lp_tech: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && lp_word_valid_i)
        |=> lp_reg[`ANR_T4_BIT:`ANR_TXHD_BIT] == $past(lp_word_i[9:7]))
        else $error("partner technology bits not loaded");

    chk_lp_sel: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && lp_word_valid_i) |=> lp_reg[`ANR_SEL_HI:0] == $past(lp_word_i[4:0]))
        else $error("partner selector not loaded");

    chk_lp_fault: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (clk_en_i && lp_word_valid_i) |=> lp_reg[`ANR_RF_BIT] == $past(lp_word_i[13]))
        else $error("partner remote fault bit not loaded");

endmodule

// *** verif/anr_lp_model.sv ***
// Purpose: behavioural link partner handing base pages to the port
// Assumes: one page per call, valid high for one cycle
// Notes:   idle word lines show the inverse of the last page
module anr_lp_model (
    input  wire logic        sys_clk_i,
    output logic      [15:0] lp_word_o,
    output logic             lp_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        lp_word_o  = 16'h0000;
        lp_valid_o = 1'b0;
    end
    // gap lets the partner answer promptly or slowly
    task automatic send(input logic [15:0] w, input int gap);
        repeat (gap) @(posedge sys_clk_i);
        lp_word_o  <= w;
        lp_valid_o <= 1'b1;
        @(posedge sys_clk_i);
        lp_valid_o <= 1'b0;
        lp_word_o  <= ~w; // stale page must not pass as a match
    endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: register-level checks of the ability register bank
// Assumes: straps held steady across each reset release
// Notes:   clock enable dropped once around a write to prove freezing
`include "anr_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, pause_s = 1;
    logic [4:0]  addr_i = '0;
    logic [3:0]  led_s = 4'ha;
    logic [15:0] wdata_i = '0, rdata_o, adv_o, lp_w, got;
    logic        lp_v, rsv_o, clk_en = 1'b1;
    int          err_count = 0, checked = 0, cyc = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    anr_lp_model lp_u (.sys_clk_i(sys_clk_i), .lp_word_o(lp_w), .lp_valid_o(lp_v));
    anr_regs dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pause_strap_i(pause_s), .indicator_config_straps_i(led_s), .lp_word_i(lp_w),
        .lp_word_valid_i(lp_v), .adv_word_o(adv_o), .reserved_sel_o(rsv_o));
    task automatic give_verdict;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask
    // straps change only while reset is held
    task automatic rst(input logic p, input logic [3:0] s);
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        pause_s  <= p;
        led_s    <= s;
        repeat (5) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
    endtask
    initial begin
        rst(1'b1, 4'ha);
        rd(`ANR_ADV_OFF, got);
        chk("adv reset", {5'h00, 1'b1, 1'b0, 4'ha, `ANR_SEL_802_3}, got);
        rd(`ANR_LP_OFF, got);
        chk("lp reset", `ANR_LP_RESET, got);
        for (int b = 5; b < 16; b++) begin
            if (b != 14) begin
                wr(`ANR_ADV_OFF, (16'h0001 << b) | 16'h0001);
                rd(`ANR_ADV_OFF, got);
                chk("adv bit", (16'h0001 << b) | 16'h0001, got);
            end
        end
        wr(`ANR_ADV_OFF, 16'hffe1);
        rd(`ANR_ADV_OFF, got);
        chk("adv ones", 16'hbfe1, got);
        chk("adv out", 16'hbfe1, adv_o);
        chk("rsv flag 802.3", 16'h0000, {15'h0000, rsv_o});
        wr(`ANR_ADV_OFF, {11'h000, `ANR_SEL_802_9});
        rd(`ANR_ADV_OFF, got);
        chk("adv sel", 16'h0002, got);
        chk("rsv flag 802.9", 16'h0000, {15'h0000, rsv_o});
        lp_u.send(16'hffe1, 0);
        rd(`ANR_LP_OFF, got);
        chk("lp page", 16'hffe1, got);
        lp_u.send(16'h4c02, 3);
        wr(`ANR_LP_OFF, 16'h0000);
        rd(`ANR_LP_OFF, got);
        chk("lp write", 16'h4c02, got);
        rd(5'h1e, got);
        chk("unmapped", 16'h0000, got);
        rst(1'b0, 4'h5);
        rd(`ANR_ADV_OFF, got);
        chk("adv strap2", {5'h00, 1'b0, 1'b0, 4'h5, `ANR_SEL_802_3}, got);
        rd(`ANR_LP_OFF, got);
        chk("lp reset2", `ANR_LP_RESET, got);
        @(posedge sys_clk_i);
        clk_en <= 1'b0;
        wr(`ANR_ADV_OFF, 16'h0021);
        clk_en <= 1'b1;
        rd(`ANR_ADV_OFF, got);
        chk("adv frozen", {5'h00, 1'b0, 1'b0, 4'h5, `ANR_SEL_802_3}, got);
        give_verdict();
    end
endmodule
